/* verilog/tctr_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tctr_top import tctr_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [2:0] DEDICATED_CLOCK_PIN,
  input wire logic SLOW_CLOCK_PIN,
  input wire logic [2:0] LINE_A_IN,
  output logic [2:0] LINE_A_OUT,
  output logic [2:0] LINE_A_OE_N,
  input wire logic [2:0] LINE_B_IN,
  output logic [2:0] LINE_B_OUT,
  output logic [2:0] LINE_B_OE_N,
  output logic [2:0] CH_IRQ
);
  typedef struct packed {
    tctr_chan_type [NCH-1:0] ch;
    logic [BMR_W-1:0] bmr;
    logic [PRE_W-1:0] pre;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] stable;
    logic [NSYNC-1:0] prev;
    logic [2:0] xc_prev;
    logic waitreq;
    logic [31:0] rdata;
  } tctr_state_type;

  typedef struct packed {
    logic acc_rd;
    logic acc_wr;
    logic [1:0] chs;
    logic [7:0] off;
    logic [31:0] rd;
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;
    logic [2:0] xc_rise;
    logic [2:0] xc_fall;
    logic [CMR_W-1:0] cmr;
    logic wave;
    logic [2:0] clksel;
    logic [1:0] burst;
    logic [1:0] mode;
    logic [1:0] evsel;
    logic sel_lvl;
    logic lvl;
    logic tick;
    logic sw;
    logic ext_ev;
    logic ext_trg;
    logic ra_hit;
    logic rb_hit;
    logic rc_hit;
    logic rc_trg;
    logic trig;
    logic ra_ev;
    logic rb_ev;
    logic lovr;
    logic stop_ev;
    logic dis_ev;
    logic ccr_wr;
    logic sync;
    logic ln_r;
    logic ln_f;
    logic b_out;
    logic [15:0] top;
    logic [15:0] cv_nx;
    logic [NFLAG-1:0] set;
  } tctr_tmp_type;

  tctr_state_type st_q;
  tctr_state_type st_d;
  tctr_tmp_type t;
  tctr_chan_type c;
  tctr_chan_type n;
  logic [2:0] a_int_w;
  logic [2:0] xc_w;
  logic [2:0] tick_w;
  logic [2:0] trig_w;
  logic [2:0] ra_load_w;

  always_comb begin : next_state
    st_d = st_q;
    t = '0;
    c = '0;
    n = '0;
    a_int_w = '0;
    xc_w = '0;
    tick_w = '0;
    trig_w = '0;
    ra_load_w = '0;
    // Three-stage synchronisers, change taken when stages two and three agree
    st_d.s1 = {SLOW_CLOCK_PIN, LINE_B_IN, LINE_A_IN, DEDICATED_CLOCK_PIN};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.stable = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.stable);
    st_d.prev = st_q.stable;
    t.rise = st_q.stable & ~st_q.prev;
    t.fall = ~st_q.stable & st_q.prev;
    st_d.pre = st_q.pre + 7'h01;
    // Bus handshake: one wait cycle, then accept
    t.acc_rd = AVS_READ & ~st_q.waitreq;
    t.acc_wr = AVS_WRITE & ~st_q.waitreq;
    st_d.waitreq = ~((AVS_READ | AVS_WRITE) & st_q.waitreq);
    t.chs = AVS_ADDRESS[CH_SEL_LSB+:2];
    t.off = {2'b00, AVS_ADDRESS[5:2], 2'b00};
    t.sync = t.acc_wr & (AVS_ADDRESS[7:2] == OFF_BCR[7:2]) & AVS_WRITEDATA[BCR_SYNC];
    if (t.acc_wr && AVS_ADDRESS[7:2] == OFF_BMR[7:2]) begin
      st_d.bmr = AVS_WRITEDATA[BMR_W-1:0];
    end
    // Internal line A: driven value in waveform mode, pin otherwise
    for (int i = 0; i < NCH; i++) begin
      a_int_w[i] = st_q.ch[i].cmr[CMR_WAVE] ? st_q.ch[i].line_a : st_q.stable[SY_LINE_A+i];
    end
    // External clock lines with chaining
    for (int k = 0; k < NCH; k++) begin
      case (st_q.bmr[2*k+:2])
        2'b00: xc_w[k] = st_q.stable[SY_TCLK+k];
        2'b01: xc_w[k] = 1'b0;
        2'b10: xc_w[k] = a_int_w[(k == 0) ? 1 : 0];
        default: xc_w[k] = a_int_w[(k == 2) ? 1 : 2];
      endcase
    end
    st_d.xc_prev = xc_w;
    t.xc_rise = xc_w & ~st_q.xc_prev;
    t.xc_fall = ~xc_w & st_q.xc_prev;
    for (int i = 0; i < NCH; i++) begin
      c = st_q.ch[i];
      n = c;
      t.cmr = c.cmr;
      t.wave = t.cmr[CMR_WAVE];
      t.clksel = t.cmr[CMR_CLKS_LSB+:3];
      t.burst = t.cmr[CMR_BURST_LSB+:2];
      t.evsel = t.cmr[CMR_EVENT_LINE_SELECT_LSB+:2];
      t.b_out = t.wave & (t.evsel != 2'b00);
      // Counting clock selection, invert and burst gate
      if (t.clksel < CLKS_SLOW) begin
        t.sel_lvl = st_q.pre[DIV_TAP[t.clksel[1:0]]];
      end else if (t.clksel == CLKS_SLOW) begin
        t.sel_lvl = st_q.stable[SY_SLOW];
      end else begin
        t.sel_lvl = xc_w[t.clksel[1:0] - 2'h1];
      end
      t.lvl = (t.sel_lvl ^ t.cmr[CMR_COUNT_EDGE_INVERT]) & ((t.burst == 2'b00) | xc_w[t.burst - 2'h1]);
      n.cnt_lvl = t.lvl;
      t.tick = t.lvl & ~c.cnt_lvl & c.clk_en & c.started;
      // Counter step by mode
      t.mode = t.wave ? t.cmr[CMR_WAVE_SELECT_LSB+:2] : WV_UP_MAX;
      t.top = t.mode[1] ? c.rc : CV_MAX;
      t.cv_nx = c.cv;
      if (t.tick) begin
        if (c.trig_pend) begin
          t.cv_nx = 16'h0000;
          n.dir = (t.mode[0] && c.dir == DIR_UP) ? DIR_DOWN : DIR_UP;
        end else if (c.dir == DIR_UP) begin
          if (c.cv != t.top) begin
            t.cv_nx = c.cv + 16'h0001;
          end else if (t.mode[0]) begin
            t.cv_nx = c.cv - 16'h0001;
            n.dir = DIR_DOWN;
          end else begin
            t.cv_nx = 16'h0000;
          end
        end else if (c.cv == 16'h0000) begin
          t.cv_nx = 16'h0001;
          n.dir = DIR_UP;
        end else begin
          t.cv_nx = c.cv - 16'h0001;
        end
      end
      n.cv = t.cv_nx;
      // Compares fire when the counter reaches the register value
      t.rc_hit = t.tick & (t.cv_nx == c.rc);
      t.ra_hit = t.tick & t.wave & (t.cv_nx == c.ra);
      t.rb_hit = t.tick & t.b_out & (t.cv_nx == c.rb);
      t.rc_trg = t.rc_hit & ~t.wave & t.cmr[CMR_RC_COMPARE_TRIGGER_ENABLE];
      // External trigger or event
      if (!t.wave) begin
        t.ln_r = t.cmr[CMR_CAPTURE_TRIGGER_LINE_SELECT] ? t.rise[SY_LINE_A+i] : t.rise[SY_LINE_B+i];
        t.ln_f = t.cmr[CMR_CAPTURE_TRIGGER_LINE_SELECT] ? t.fall[SY_LINE_A+i] : t.fall[SY_LINE_B+i];
        t.ext_ev = tctr_edge_hit(t.cmr[CMR_EDG_LSB+:2], t.ln_r, t.ln_f);
        t.ext_trg = t.ext_ev;
      end else begin
        if (t.evsel == 2'b00) begin
          t.ln_r = t.rise[SY_LINE_B+i];
          t.ln_f = t.fall[SY_LINE_B+i];
        end else begin
          t.ln_r = t.xc_rise[t.evsel - 2'h1];
          t.ln_f = t.xc_fall[t.evsel - 2'h1];
        end
        t.ext_ev = tctr_edge_hit(t.cmr[CMR_EDG_LSB+:2], t.ln_r, t.ln_f);
        t.ext_trg = t.ext_ev & t.cmr[CMR_EXTERNAL_TRIGGER_ENABLE];
      end
      t.ccr_wr = t.acc_wr & (t.chs == 2'(i)) & (t.off == OFF_CCR);
      t.sw = t.ccr_wr & AVS_WRITEDATA[CCR_SOFTWARE_TRIGGER_CMD];
      t.trig = t.sw | t.sync | t.ext_trg | t.rc_trg;
      // Capture loads alternate A then B
      t.ra_ev = ~t.wave & ~c.seq_b & tctr_edge_hit(t.cmr[CMR_RA_LOAD_EDGE_LSB+:2], t.rise[SY_LINE_A+i], t.fall[SY_LINE_A+i]);
      t.rb_ev = ~t.wave & c.seq_b & tctr_edge_hit(t.cmr[CMR_RB_LOAD_EDGE_LSB+:2], t.rise[SY_LINE_A+i], t.fall[SY_LINE_A+i]);
      t.lovr = (t.ra_ev & c.ra_unread) | (t.rb_ev & c.rb_unread);
      if (t.ra_ev) begin
        n.ra = c.cv;
        n.seq_b = 1'b1;
        n.ra_unread = 1'b1;
      end
      if (t.rb_ev) begin
        n.rb = c.cv;
        n.seq_b = 1'b0;
        n.rb_unread = 1'b1;
      end
      if (t.trig) begin
        n.seq_b = 1'b0;
        n.trig_pend = 1'b1;
      end else if (t.tick) begin
        n.trig_pend = 1'b0;
      end
      // Clock control
      t.stop_ev = t.wave ? (t.rc_hit & t.cmr[CMR_STOP]) : (t.rb_ev & t.cmr[CMR_STOP]);
      t.dis_ev = t.wave ? (t.rc_hit & t.cmr[CMR_DIS]) : (t.rb_ev & t.cmr[CMR_DIS]);
      if ((t.ccr_wr && AVS_WRITEDATA[CCR_DIS]) || t.dis_ev) begin
        n.clk_en = 1'b0;
      end else if (t.ccr_wr && AVS_WRITEDATA[CCR_EN]) begin
        n.clk_en = 1'b1;
      end
      if (n.clk_en) begin
        if (t.trig) begin
          n.started = 1'b1;
        end else if (t.stop_ev) begin
          n.started = 1'b0;
        end
      end
      // Line levels in waveform mode
      if (t.rc_hit) begin
        n.line_a = 1'b0;
      end else if (t.ra_hit) begin
        n.line_a = 1'b1;
      end
      if (t.rc_hit && t.b_out) begin
        n.line_b = 1'b0;
      end else if (t.rb_hit) begin
        n.line_b = 1'b1;
      end
      n.oe_a_n = ~t.wave;
      n.oe_b_n = ~t.b_out;
      // Software access to channel registers
      if (t.acc_wr && t.chs == 2'(i)) begin
        if (t.off == OFF_CMR) begin
          n.cmr = AVS_WRITEDATA[CMR_W-1:0];
        end else if (t.off == OFF_RA && t.wave) begin
          n.ra = AVS_WRITEDATA[15:0];
        end else if (t.off == OFF_RB && t.wave) begin
          n.rb = AVS_WRITEDATA[15:0];
        end else if (t.off == OFF_RC) begin
          n.rc = AVS_WRITEDATA[15:0];
        end else if (t.off == OFF_IER) begin
          n.imr = c.imr | AVS_WRITEDATA[NFLAG-1:0];
        end else if (t.off == OFF_IDR) begin
          n.imr = c.imr & ~AVS_WRITEDATA[NFLAG-1:0];
        end
      end
      if (t.acc_rd && t.chs == 2'(i) && t.off == OFF_RA && !t.ra_ev) begin
        n.ra_unread = 1'b0;
      end
      if (t.acc_rd && t.chs == 2'(i) && t.off == OFF_RB && !t.rb_ev) begin
        n.rb_unread = 1'b0;
      end
      // Sticky flags, set wins over read clear
      t.set = '0;
      t.set[SR_COUNTER_OVERFLOW_FLAG] = t.tick & (c.cv == CV_MAX) & (t.cv_nx == 16'h0000);
      t.set[SR_LOAD_OVERRUN_FLAG] = t.lovr;
      t.set[SR_CPAS] = t.ra_hit;
      t.set[SR_CPBS] = t.rb_hit;
      t.set[SR_CPCS] = t.rc_hit;
      t.set[SR_LDRAS] = t.ra_ev;
      t.set[SR_LDRBS] = t.rb_ev;
      t.set[SR_ETRGS] = t.ext_trg;
      if (t.acc_rd && t.chs == 2'(i) && t.off == OFF_SR) begin
        n.flags = t.set;
      end else begin
        n.flags = c.flags | t.set;
      end
      n.irq = |(n.flags & n.imr);
      st_d.ch[i] = n;
      tick_w[i] = t.tick;
      trig_w[i] = t.trig;
      ra_load_w[i] = t.ra_ev;
    end
    // Read data captured in the wait cycle
    t.rd = '0;
    if (AVS_ADDRESS[7:2] == OFF_BMR[7:2]) begin
      t.rd[BMR_W-1:0] = st_q.bmr;
    end else if (t.chs != 2'b11) begin
      c = st_q.ch[t.chs];
      if (t.off == OFF_CMR) begin
        t.rd[CMR_W-1:0] = c.cmr;
      end else if (t.off == OFF_CV) begin
        t.rd[15:0] = c.cv;
      end else if (t.off == OFF_RA) begin
        t.rd[15:0] = c.ra;
      end else if (t.off == OFF_RB) begin
        t.rd[15:0] = c.rb;
      end else if (t.off == OFF_RC) begin
        t.rd[15:0] = c.rc;
      end else if (t.off == OFF_SR) begin
        t.rd[NFLAG-1:0] = c.flags;
        t.rd[SR_CLOCK_ENABLED_FLAG] = c.clk_en;
      end else if (t.off == OFF_IMR) begin
        t.rd[NFLAG-1:0] = c.imr;
      end
    end
    if (AVS_READ && st_q.waitreq) begin
      st_d.rdata = t.rd;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin : state_reg
    if (!RESETN) begin
      st_q <= '0;
      st_q.waitreq <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        st_q.ch[i].oe_a_n <= 1'b1;
        st_q.ch[i].oe_b_n <= 1'b1;
      end
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin : out_map
    AVS_READDATA = st_q.rdata;
    AVS_WAITREQUEST = st_q.waitreq;
    for (int i = 0; i < NCH; i++) begin
      LINE_A_OUT[i] = st_q.ch[i].line_a;
      LINE_A_OE_N[i] = st_q.ch[i].oe_a_n;
      LINE_B_OUT[i] = st_q.ch[i].line_b;
      LINE_B_OE_N[i] = st_q.ch[i].oe_b_n;
      CH_IRQ[i] = st_q.ch[i].irq;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_count_step: assert property (
      tick_w[g] && !st_q.ch[g].trig_pend && !st_q.ch[g].cmr[CMR_WAVE] && st_q.ch[g].cv != CV_MAX
      |=> st_q.ch[g].cv == $past(st_q.ch[g].cv) + 16'h0001)
      else $error("counter did not step by one");
    a_overflow_flag: assert property (
      tick_w[g] && !st_q.ch[g].trig_pend && !st_q.ch[g].cmr[CMR_WAVE] && st_q.ch[g].cv == CV_MAX
      |=> st_q.ch[g].flags[SR_COUNTER_OVERFLOW_FLAG] && st_q.ch[g].cv == 16'h0000)
      else $error("overflow flag missing on wrap");
    a_trigger_late: assert property (
      trig_w[g] |=> st_q.ch[g].trig_pend)
      else $error("trigger not held until clock edge");
    a_trigger_zero: assert property (
      tick_w[g] && st_q.ch[g].trig_pend |=> st_q.ch[g].cv == 16'h0000)
      else $error("trigger did not clear counter");
    a_disable_wins: assert property (
      AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[7:6] == 2'(g) && AVS_ADDRESS[5:2] == 4'h0
      && AVS_WRITEDATA[CCR_DIS] |=> !st_q.ch[g].clk_en)
      else $error("disable command lost");
    a_start_disabled: assert property (
      !st_q.ch[g].clk_en && !st_d.ch[g].clk_en |=> st_q.ch[g].started == $past(st_q.ch[g].started))
      else $error("start or stop acted while disabled");
    a_line_dir: assert property (
      !st_q.ch[g].cmr[CMR_WAVE] |=> LINE_A_OE_N[g] && LINE_B_OE_N[g])
      else $error("line driven in capture mode");
    a_rb_order: assert property (
      ra_load_w[g] && !trig_w[g] |=> st_q.ch[g].seq_b && st_q.ch[g].ra == $past(st_q.ch[g].cv))
      else $error("register A load sequence broken");
    a_load_overrun: assert property (
      ra_load_w[g] && st_q.ch[g].ra_unread |=> st_q.ch[g].flags[SR_LOAD_OVERRUN_FLAG])
      else $error("overrun flag missing");
    a_rc_wrap: assert property (
      tick_w[g] && st_q.ch[g].cmr[CMR_WAVE] && st_q.ch[g].cmr[CMR_WAVE_SELECT_LSB+:2] == WV_UP_RC
      && !st_q.ch[g].trig_pend && st_q.ch[g].dir == DIR_UP && st_q.ch[g].cv == st_q.ch[g].rc
      |=> st_q.ch[g].cv == 16'h0000)
      else $error("counter did not clear at RC");
    a_irq_mask: assert property (
      CH_IRQ[g] == |(st_q.ch[g].flags & st_q.ch[g].imr))
      else $error("interrupt does not match masked flags");
  end
endmodule : tctr_top
`default_nettype wire

/* verilog/tctr_pkg.sv */
`default_nettype none
package tctr_pkg;
  localparam int NCH = 3;
  // Byte addresses, low two bits ignored
  localparam logic [7:0] OFF_CCR = 8'h00;
  localparam logic [7:0] OFF_CMR = 8'h04;
  localparam logic [7:0] OFF_CV = 8'h10;
  localparam logic [7:0] OFF_RA = 8'h14;
  localparam logic [7:0] OFF_RB = 8'h18;
  localparam logic [7:0] OFF_RC = 8'h1C;
  localparam logic [7:0] OFF_SR = 8'h20;
  localparam logic [7:0] OFF_IER = 8'h24;
  localparam logic [7:0] OFF_IDR = 8'h28;
  localparam logic [7:0] OFF_IMR = 8'h2C;
  localparam logic [7:0] OFF_BCR = 8'hC0;
  localparam logic [7:0] OFF_BMR = 8'hC4;
  localparam int CH_SEL_LSB = 6;
  // Control and block fields
  localparam int CCR_EN = 0;
  localparam int CCR_DIS = 1;
  localparam int CCR_SOFTWARE_TRIGGER_CMD = 2;
  localparam int BCR_SYNC = 0;
  localparam int BMR_W = 6;
  // Mode register fields
  localparam int CMR_W = 20;
  localparam int CMR_CLKS_LSB = 0;
  localparam int CMR_COUNT_EDGE_INVERT = 3;
  localparam int CMR_BURST_LSB = 4;
  localparam int CMR_STOP = 6;
  localparam int CMR_DIS = 7;
  localparam int CMR_EDG_LSB = 8;
  localparam int CMR_CAPTURE_TRIGGER_LINE_SELECT = 10;
  localparam int CMR_EVENT_LINE_SELECT_LSB = 10;
  localparam int CMR_EXTERNAL_TRIGGER_ENABLE = 12;
  localparam int CMR_WAVE_SELECT_LSB = 13;
  localparam int CMR_RC_COMPARE_TRIGGER_ENABLE = 14;
  localparam int CMR_WAVE = 15;
  localparam int CMR_RA_LOAD_EDGE_LSB = 16;
  localparam int CMR_RB_LOAD_EDGE_LSB = 18;
  // Status fields
  localparam int NFLAG = 8;
  localparam int SR_COUNTER_OVERFLOW_FLAG = 0;
  localparam int SR_LOAD_OVERRUN_FLAG = 1;
  localparam int SR_CPAS = 2;
  localparam int SR_CPBS = 3;
  localparam int SR_CPCS = 4;
  localparam int SR_LDRAS = 5;
  localparam int SR_LDRBS = 6;
  localparam int SR_ETRGS = 7;
  localparam int SR_CLOCK_ENABLED_FLAG = 16;
  // Prescaler taps for divide by 2, 8, 32, 128
  localparam int PRE_W = 7;
  localparam int DIV_TAP [4] = '{0, 2, 4, 6};
  localparam int NSYNC = 10;
  localparam int SY_TCLK = 0;
  localparam int SY_LINE_A = 3;
  localparam int SY_LINE_B = 6;
  localparam int SY_SLOW = 9;
  localparam logic [15:0] CV_MAX = 16'hFFFF;
  localparam logic [2:0] CLKS_SLOW = 3'h4;

  typedef enum logic [1:0] {
    WV_UP_MAX = 2'b00,
    WV_UPDN_MAX = 2'b01,
    WV_UP_RC = 2'b10,
    WV_UPDN_RC = 2'b11
  } tctr_wave_type;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } tctr_dir_type;

  typedef struct packed {
    logic [CMR_W-1:0] cmr;
    logic [15:0] cv;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] imr;
    logic clk_en;
    logic started;
    logic trig_pend;
    logic cnt_lvl;
    tctr_dir_type dir;
    logic seq_b;
    logic ra_unread;
    logic rb_unread;
    logic line_a;
    logic line_b;
    logic oe_a_n;
    logic oe_b_n;
    logic irq;
  } tctr_chan_type;

  // Edge code: 0 none, 1 rising, 2 falling, 3 both
  function automatic logic tctr_edge_hit(input logic [1:0] code, input logic r, input logic f);
    return (code[0] & r) | (code[1] & f);
  endfunction : tctr_edge_hit
endpackage : tctr_pkg
`default_nettype wire

/* bench/tctr_src.sv */
`timescale 1ns/100ps
`default_nettype none
module tctr_src (
  input wire logic clk,
  output logic [2:0] ded,
  output logic slow,
  output logic [2:0] line_a,
  output logic [2:0] line_b
);
  initial begin
    ded = 3'h0;
    slow = 1'b0;
    line_a = 3'h0;
    line_b = 3'h0;
  end
  // Free running slow clock
  always begin
    repeat (16) @(posedge clk);
    slow <= ~slow;
  end
  // Each level held four cycles or more
  task clk_pulses(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      ded[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      ded[idx] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : clk_pulses
  task gate(input logic v);
    @(posedge clk);
    ded[1] <= v;
  endtask : gate
  task line_a_pulse(input int w);
    @(posedge clk);
    line_a[0] <= 1'b1;
    repeat (w) @(posedge clk);
    line_a[0] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : line_a_pulse
endmodule : tctr_src
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench import tctr_pkg::*; ;
  logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest, slow;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, ra, base, last, ev;
  logic [2:0] ded, src_a, src_b, pad_a, pad_b, a_out, a_oe_n, b_out, b_oe_n, ch_irq;
  logic [31:0] q [$];
  logic [7:0] rst_addr [9] = '{OFF_CMR, OFF_CV, OFF_RA, OFF_RB, OFF_RC, OFF_SR, OFF_IMR, OFF_BMR, 8'h08};
  logic [31:0] ex_cmr [6] = '{32'h5, 32'h5, 32'h5, 32'h25, 32'h25, 32'hD};
  int ex_bmr [6] = '{0, 0, 1, 0, 0, 0};
  int ex_gate [6] = '{0, 0, 0, 0, 1, 0};
  int ex_n [6] = '{5, 3, 4, 4, 4, 4};
  int ex_tick [6] = '{1, 1, 0, 0, 1, 1};
  int ex_base [6] = '{1, 1, 0, 0, 1, 0};
  int bad_count, checks_done, seed, rc, e, p, up, c, k, ws;
  // Pad level from both drivers
  assign pad_a = (a_oe_n & src_a) | (~a_oe_n & a_out);
  assign pad_b = (b_oe_n & src_b) | (~b_oe_n & b_out);
  tctr_top uut (.REF_CLK(ref_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .DEDICATED_CLOCK_PIN(ded), .SLOW_CLOCK_PIN(slow),
    .LINE_A_IN(pad_a), .LINE_A_OUT(a_out), .LINE_A_OE_N(a_oe_n), .LINE_B_IN(pad_b),
    .LINE_B_OUT(b_out), .LINE_B_OE_N(b_oe_n), .CH_IRQ(ch_irq));
  tctr_src src (.clk(ref_clk), .ded(ded), .slow(slow), .line_a(src_a), .line_b(src_b));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // Avalon transfer, read kept high for n words
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input int n);
    int i;
    int j;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    q.delete();
    for (j = 0; j < n; j++) begin
      for (i = 0; i < 20; i++) begin
        @(posedge ref_clk);
        if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
        bad_count++;
        final_report();
      end
      q.push_back(avs_readdata);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 1);
    rd = q[0];
  endtask : rdr
  initial begin
    seed = 3;
    bad_count = 0;
    checks_done = 0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    resetn = 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rst_addr[i]) begin
      rdr(rst_addr[i]);
      `CHK("reset value", 32'h0, rd)
    end
    $display("test reset done");
    wr(OFF_CMR, 32'h0);
    wr(OFF_CCR, 32'h5);
    repeat (4) @(posedge ref_clk);
    xfer(1'b0, OFF_CV, 32'h0, 6);
    for (k = 1; k < 6; k++) `CHK("cv step", q[k-1] + 32'h1, q[k])
    rdr(OFF_SR);
    `CHK("clock on", 32'h10000, rd & 32'h10000)
    wr(OFF_CCR, 32'h3);
    rdr(OFF_SR);
    `CHK("enable with disable", 32'h0, rd & 32'h10000)
    xfer(1'b0, OFF_CV, 32'h0, 3);
    `CHK("cv held", q[0], q[2])
    $display("test clock control done");
    last = 32'h0;
    for (c = 0; c < 6; c++) begin
      src.gate(ex_gate[c][0]);
      wr(OFF_BMR, 32'(ex_bmr[c]));
      wr(OFF_CMR, ex_cmr[c]);
      wr(OFF_CCR, 32'h5);
      rdr(OFF_CV);
      if (c == 1) `CHK("cv before tick", last, rd)
      src.clk_pulses(0, 1);
      repeat (8) @(posedge ref_clk);
      rdr(OFF_CV);
      base = rd;
      if (ex_base[c] == 1) `CHK("cv after trigger", 32'h0, rd)
      src.clk_pulses(0, ex_n[c]);
      repeat (8) @(posedge ref_clk);
      rdr(OFF_CV);
      `CHK("ext count", base + 32'(ex_tick[c] * ex_n[c]), rd)
      last = rd;
    end
    $display("test external clock done");
    for (ws = 2; ws < 4; ws++) begin
      rc = 3 + ($random(seed) & 7);
      wr(OFF_RC, 32'(rc));
      rdr(OFF_RC);
      `CHK("rc readback", 32'(rc), rd)
      wr(OFF_CMR, 32'h8000 | 32'(ws << 13) | ((ws == 3) ? 32'h400 : 32'h0));
      repeat (2) @(posedge ref_clk);
      `CHK("a drive", 1'b0, a_oe_n[0])
      `CHK("b drive", (ws == 3) ? 1'b0 : 1'b1, b_oe_n[0])
      wr(OFF_CCR, 32'h5);
      xfer(1'b0, OFF_CV, 32'h0, 4 * rc + 4);
      p = q[2];
      up = 1;
      for (k = 3; k < 4 * rc + 4; k++) begin
        if (ws == 2) e = (p == rc) ? 0 : p + 1;
        else if (up == 1) begin
          up = (p == rc) ? 0 : 1;
          e = (p == rc) ? p - 1 : p + 1;
        end else begin
          up = (p == 0) ? 1 : 0;
          e = (p == 0) ? 1 : p - 1;
        end
        ev = 32'(e);
        if (ws == 2) `CHK("cv wave up", ev, q[k])
        else `CHK("cv wave updown", ev, q[k])
        p = int'(q[k]);
      end
      wr(OFF_CCR, 32'h2);
    end
    wr(OFF_CMR, 32'hC080);
    wr(OFF_CCR, 32'h5);
    repeat (4 * rc + 20) @(posedge ref_clk);
    rdr(OFF_SR);
    `CHK("rc disables", 32'h0, rd & 32'h10000)
    rdr(OFF_CV);
    `CHK("cv stuck at rc", 32'(rc), rd)
    $display("test waveform done");
    wr(OFF_CMR, 32'h90000);
    wr(OFF_IER, 32'h20);
    wr(OFF_CCR, 32'h5);
    src.line_a_pulse(40);
    repeat (10) @(posedge ref_clk);
    `CHK("irq", 1'b1, ch_irq[0])
    `CHK("capture inputs", 2'h3, {a_oe_n[0], b_oe_n[0]})
    rdr(OFF_RA);
    ra = rd;
    rdr(OFF_RB);
    `CHK("rb minus ra", 32'h14, rd - ra)
    rdr(OFF_SR);
    `CHK("load flags", 32'h60, rd & 32'h62)
    repeat (2) @(posedge ref_clk);
    `CHK("irq cleared", 1'b0, ch_irq[0])
    src.line_a_pulse(40);
    src.line_a_pulse(40);
    repeat (10) @(posedge ref_clk);
    rdr(OFF_SR);
    `CHK("overrun", 32'h2, rd & 32'h2)
    $display("test capture done");
    wr(8'h40, 32'h1);
    wr(8'h80, 32'h1);
    repeat (10) @(posedge ref_clk);
    rdr(8'h90);
    `CHK("not started", 32'h0, rd)
    wr(OFF_BCR, 32'h1);
    repeat (10) @(posedge ref_clk);
    rdr(8'h50);
    `CHK("ch1 synced", 1'b1, rd != 32'h0)
    rdr(8'h90);
    `CHK("ch2 synced", 1'b1, rd != 32'h0)
    $display("test sync done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
